// ### hw/mmccb_bridge.sv
// Memory-mapped clock crossing bridge, top level
`timescale 1ns/1ps
`default_nettype none
module mmccb_bridge #(
   parameter int DATA_W    = mmccb_pkg::DEF_DATA_W,
   parameter int SYM_W     = mmccb_pkg::DEF_SYM_W,
   parameter int ADDR_W    = mmccb_pkg::DEF_ADDR_W,
   parameter int MAX_BURST = mmccb_pkg::DEF_MAX_BURST,
   parameter int CMD_DEPTH = mmccb_pkg::DEF_CMD_DEPTH,
   parameter int RSP_DEPTH = 2 * MAX_BURST,
   parameter int M2S_SYNC  = mmccb_pkg::DEF_SYNC,
   parameter int S2M_SYNC  = mmccb_pkg::DEF_SYNC
) (
   // Upstream clock, reset, enable
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic                    ce,
   // Register bus
   input  wire logic [3:0]              s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic      [1:0]              s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [3:0]              s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic      [31:0]             s_axi_rdata,
   output logic      [1:0]              s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   // Upstream slave port
   input  wire logic [ADDR_W-1:0]       s_address,
   input  wire logic                    s_read,
   input  wire logic                    s_write,
   input  wire logic [DATA_W-1:0]       s_writedata,
   input  wire logic [DATA_W/SYM_W-1:0] s_byteenable,
   input  wire logic [$clog2(MAX_BURST):0] s_burstcount,
   output logic                         s_waitrequest,
   output logic      [DATA_W-1:0]       s_readdata,
   output logic                         s_readdatavalid,
   // Downstream clock and reset
   input  wire logic                    m_clk,
   input  wire logic                    m_resetn,
   // Downstream master port
   output logic      [ADDR_W-1:0]       m_address,
   output logic                         m_read,
   output logic                         m_write,
   output logic      [DATA_W-1:0]       m_writedata,
   output logic      [DATA_W/SYM_W-1:0] m_byteenable,
   output logic      [$clog2(MAX_BURST):0] m_burstcount,
   input  wire logic                    m_waitrequest,
   input  wire logic [DATA_W-1:0]       m_readdata,
   input  wire logic                    m_readdatavalid
);
   localparam int BE_W   = DATA_W / SYM_W;
   localparam int BC_W   = $clog2(MAX_BURST) + 1;
   localparam int CMD_W  = 1 + ADDR_W + BC_W + BE_W + DATA_W;
   localparam int CAW    = $clog2(CMD_DEPTH);
   localparam int RAW    = $clog2(RSP_DEPTH);
   localparam int OST_W  = RAW + 1;
   localparam logic [OST_W-1:0] RSP_LIMIT = OST_W'(RSP_DEPTH);
   localparam logic [CAW:0]     CMD_LIMIT = (CAW+1)'(CMD_DEPTH);

   ////////////////////////////////////////////////////////////////////////////
   // Register bus slave
   logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic        aw_got_r, w_got_r, enable_r;
   logic [3:0]  waddr_r;
   logic [31:0] wdata_r, rdata_r;
   logic [3:0]  wstrb_r;
   logic [1:0]  bresp_r, rresp_r;
   logic [OST_W-1:0] outst_r;
   logic        wait_r;
   logic        rsp_valid;

   wire         aw_go    = s_axi_awvalid && awready_r;
   wire         w_go     = s_axi_wvalid && wready_r;
   wire         aw_have  = aw_got_r || aw_go;
   wire         w_have   = w_got_r || w_go;
   wire         do_wr    = aw_have && w_have && !bvalid_r;
   wire [3:0]   wa_eff   = aw_go ? s_axi_awaddr : waddr_r;
   wire [31:0]  wd_eff   = w_go ? s_axi_wdata : wdata_r;
   wire [3:0]   ws_eff   = w_go ? s_axi_wstrb : wstrb_r;
   wire         wr_ctrl  = wa_eff == mmccb_pkg::CTRL_OFFSET;
   wire         wr_ok    = wr_ctrl || wa_eff == mmccb_pkg::STATUS_OFFSET;
   wire         bvalid_nxt  = do_wr || (bvalid_r && !s_axi_bready);
   wire         aw_got_nxt  = aw_have && !do_wr;
   wire         w_got_nxt   = w_have && !do_wr;
   wire         ar_go    = s_axi_arvalid && arready_r;
   wire         rvalid_nxt  = ar_go || (rvalid_r && !s_axi_rready);
   wire         rd_ctrl  = s_axi_araddr == mmccb_pkg::CTRL_OFFSET;
   wire         rd_stat  = s_axi_araddr == mmccb_pkg::STATUS_OFFSET;

   // Status word shows live bridge state
   wire [31:0]  ctrl_word = 32'(enable_r) << mmccb_pkg::CTRL_ENABLE_BIT;
   wire [31:0]  stat_word = (32'(outst_r) << mmccb_pkg::STAT_OUTST_LSB)
                          | (32'(wait_r) << mmccb_pkg::STAT_WAIT_BIT)
                          | (32'(rsp_valid) << mmccb_pkg::STAT_RSPNE_BIT);
   wire [31:0]  rd_word   = rd_ctrl ? ctrl_word : (rd_stat ? stat_word : 32'h0000_0000);

   // Write channel handshakes, either order accepted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r  <= 1'b0;
         w_got_r   <= 1'b0;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= mmccb_pkg::RESP_OKAY;
         waddr_r   <= 4'h0;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         enable_r  <= mmccb_pkg::CTRL_ENABLE_RST;
      end else if (ce) begin
         aw_got_r  <= aw_got_nxt;
         w_got_r   <= w_got_nxt;
         awready_r <= !aw_got_nxt && !bvalid_nxt;
         wready_r  <= !w_got_nxt && !bvalid_nxt;
         bvalid_r  <= bvalid_nxt;
         if (aw_go) waddr_r <= s_axi_awaddr;
         if (w_go) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_wr) bresp_r <= wr_ok ? mmccb_pkg::RESP_OKAY : mmccb_pkg::RESP_SLVERR;
         if (do_wr && wr_ctrl && ws_eff[0]) enable_r <= wd_eff[mmccb_pkg::CTRL_ENABLE_BIT];
      end
   end

   // Read channel, one read in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= mmccb_pkg::RESP_OKAY;
      end else if (ce) begin
         arready_r <= !rvalid_nxt;
         rvalid_r  <= rvalid_nxt;
         if (ar_go) begin
            rdata_r <= rd_word;
            rresp_r <= (rd_ctrl || rd_stat) ? mmccb_pkg::RESP_OKAY : mmccb_pkg::RESP_SLVERR;
         end
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   ////////////////////////////////////////////////////////////////////////////
   // Upstream command intake
   logic [CAW:0]      cmd_level;
   logic              cmd_full;
   logic [DATA_W-1:0] rsp_data;
   logic [DATA_W-1:0] rdata_up_r;
   logic              rdv_up_r;

   wire               cmd_take = (s_read || s_write) && !wait_r;
   wire               rd_take  = s_read && !wait_r;
   wire               rsp_pop  = rsp_valid;
   wire [CMD_W-1:0]   cmd_word = {s_write, s_address, s_burstcount, s_byteenable, s_writedata};
   wire [OST_W-1:0]   burst_ost = OST_W'(s_burstcount);
   // Reads are charged their whole burst at acceptance
   wire [OST_W-1:0]   outst_nxt = outst_r + (rd_take ? burst_ost : OST_W'(0))
                                  - OST_W'(rsp_pop);
   wire [OST_W:0]     ost_need  = (OST_W+1)'(outst_nxt) + (OST_W+1)'(MAX_BURST);
   // Wait-request is registered, so it must look one beat ahead
   wire               cmd_nfull = ((CAW+1)'(cmd_level) + (CAW+1)'(cmd_take)) >= CMD_LIMIT;
   wire               wait_nxt  = !enable_r || cmd_nfull
                                  || ost_need > (OST_W+1)'(RSP_LIMIT);

   // Outstanding read credit and upstream answers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         outst_r    <= '0;
         wait_r     <= 1'b1;
         rdv_up_r   <= 1'b0;
         rdata_up_r <= '0;
      end else if (ce) begin
         outst_r    <= outst_nxt;
         wait_r     <= wait_nxt;
         rdv_up_r   <= rsp_pop;
         if (rsp_pop) rdata_up_r <= rsp_data;
      end
   end

   assign s_waitrequest   = wait_r;
   assign s_readdata      = rdata_up_r;
   assign s_readdatavalid = rdv_up_r;

   ////////////////////////////////////////////////////////////////////////////
   // Clock crossing queues
   logic [CMD_W-1:0] cmd_head;
   logic             cmd_valid, cmd_pop, en_m;

   // Command queue, upstream writes, downstream reads in order
   mmccb_async_fifo #(.W(CMD_W), .AW(CAW), .WSYNC(S2M_SYNC), .RSYNC(M2S_SYNC)) u_cmd_q (
      .wclk(aclk), .wrst_n(aresetn), .w_ce(ce), .w_push(cmd_take), .w_data(cmd_word),
      .w_full(cmd_full), .w_level(cmd_level),
      .rclk(m_clk), .rrst_n(m_resetn), .r_ce(1'b1), .r_pop(cmd_pop), .r_data(cmd_head),
      .r_valid(cmd_valid));

   // Response queue, never overflows thanks to read credit
   mmccb_async_fifo #(.W(DATA_W), .AW(RAW), .WSYNC(M2S_SYNC), .RSYNC(S2M_SYNC)) u_rsp_q (
      .wclk(m_clk), .wrst_n(m_resetn), .w_ce(1'b1), .w_push(m_readdatavalid),
      .w_data(m_readdata), .w_full(), .w_level(),
      .rclk(aclk), .rrst_n(aresetn), .r_ce(ce), .r_pop(rsp_pop), .r_data(rsp_data),
      .r_valid(rsp_valid));

   // Enable level into the downstream domain
   mmccb_sync #(.W(1), .STAGES(M2S_SYNC)) u_en_sync (
      .clk(m_clk), .rst_n(m_resetn), .ce(1'b1), .din(enable_r), .dout(en_m));

   ////////////////////////////////////////////////////////////////////////////
   // Downstream master issue
   logic              m_busy_r, m_wr_r;
   logic [ADDR_W-1:0] m_addr_r;
   logic [BC_W-1:0]   m_bc_r;
   logic [BE_W-1:0]   m_be_r;
   logic [DATA_W-1:0] m_wd_r;

   // Head of queue loads once the held command is taken
   wire               m_free = !m_busy_r || !m_waitrequest;
   assign cmd_pop = cmd_valid && m_free && en_m;

   always_ff @(posedge m_clk) begin
      if (!m_resetn) begin
         m_busy_r <= 1'b0;
         m_wr_r   <= 1'b0;
         m_addr_r <= '0;
         m_bc_r   <= '0;
         m_be_r   <= '0;
         m_wd_r   <= '0;
      end else if (m_free) begin
         m_busy_r <= cmd_pop;
         if (cmd_pop) begin
            {m_wr_r, m_addr_r, m_bc_r, m_be_r, m_wd_r} <= cmd_head;
         end
      end
   end

   assign m_read       = m_busy_r && !m_wr_r;
   assign m_write      = m_busy_r && m_wr_r;
   assign m_address    = m_addr_r;
   assign m_burstcount = m_bc_r;
   assign m_byteenable = m_be_r;
   assign m_writedata  = m_wd_r;
endmodule // mmccb_bridge
`default_nettype wire

// ### common/mmccb_pkg.sv
// Shared constants for the memory-mapped clock crossing bridge
package mmccb_pkg;
   // Register byte offsets
   localparam logic [3:0] CTRL_OFFSET   = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   // Control fields and reset value
   localparam int         CTRL_ENABLE_BIT = 0;
   localparam logic       CTRL_ENABLE_RST = 1'b1;
   // Status field positions
   localparam int         STAT_OUTST_LSB = 0;
   localparam int         STAT_WAIT_BIT  = 16;
   localparam int         STAT_RSPNE_BIT = 17;
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Build-time defaults
   localparam int         DEF_DATA_W    = 32;
   localparam int         DEF_SYM_W     = 8;
   localparam int         DEF_ADDR_W    = 32;
   localparam int         DEF_MAX_BURST = 16;
   localparam int         DEF_CMD_DEPTH = 16;
   localparam int         DEF_SYNC      = 2;
   // Widest pointer handled by the gray decoder
   localparam int         PTR_MAX_W = 16;

   // Gray to binary, used by the read pointer crossing only
   function automatic logic [PTR_MAX_W-1:0] gray2bin(input logic [PTR_MAX_W-1:0] g);
      logic [PTR_MAX_W-1:0] b;
      b = g;
      for (int i = PTR_MAX_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction
endpackage

// ### hw/mmccb_sync.sv
// Multi-stage level synchroniser
`timescale 1ns/1ps
`default_nettype none
module mmccb_sync #(
   parameter int W      = 1,
   parameter int STAGES = 2
) (
   // Destination clock
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   // Level in and out
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] stage_r [0:STAGES-1];

   // Only the next stage reads the first one
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < STAGES; i++) stage_r[i] <= '0;
      end else if (ce) begin
         stage_r[0] <= din;
         for (int i = 1; i < STAGES; i++) stage_r[i] <= stage_r[i-1];
      end
   end

   assign dout = stage_r[STAGES-1];
endmodule // mmccb_sync
`default_nettype wire

// ### hw/mmccb_async_fifo.sv
// Dual-clock FIFO with gray-coded pointers
`timescale 1ns/1ps
`default_nettype none
module mmccb_async_fifo #(
   parameter int W     = 8,
   parameter int AW    = 2,
   parameter int WSYNC = 2,
   parameter int RSYNC = 2
) (
   // Write domain
   input  wire logic          wclk,
   input  wire logic          wrst_n,
   input  wire logic          w_ce,
   input  wire logic          w_push,
   input  wire logic [W-1:0]  w_data,
   output logic               w_full,
   output logic      [AW:0]   w_level,
   // Read domain
   input  wire logic          rclk,
   input  wire logic          rrst_n,
   input  wire logic          r_ce,
   input  wire logic          r_pop,
   output logic      [W-1:0]  r_data,
   output logic               r_valid
);
   logic [W-1:0] mem [0:(1<<AW)-1];
   logic [AW:0]  wbin_r, wgray_r, rbin_r, rgray_r;
   logic [AW:0]  rgray_w, wgray_rd, rbin_w;
   logic [mmccb_pkg::PTR_MAX_W-1:0] rbin_full;
   wire          do_push = w_ce && w_push && !w_full;
   wire          do_pop  = r_ce && r_pop && r_valid;
   wire [AW:0]   wbin_nxt = wbin_r + (AW+1)'(1);
   wire [AW:0]   rbin_nxt = rbin_r + (AW+1)'(1);

   // Read pointer into write domain
   mmccb_sync #(.W(AW+1), .STAGES(WSYNC)) u_rsync (
      .clk(wclk), .rst_n(wrst_n), .ce(w_ce), .din(rgray_r), .dout(rgray_w));
   // Write pointer into read domain
   mmccb_sync #(.W(AW+1), .STAGES(RSYNC)) u_wsync (
      .clk(rclk), .rst_n(rrst_n), .ce(r_ce), .din(wgray_r), .dout(wgray_rd));

   // Level seen by the writer lags pops, so it errs toward full
   assign rbin_full = mmccb_pkg::gray2bin(mmccb_pkg::PTR_MAX_W'(rgray_w));
   assign rbin_w    = rbin_full[AW:0];
   assign w_level   = wbin_r - rbin_w;
   assign w_full    = w_level[AW];
   assign r_valid   = wgray_rd != rgray_r;
   assign r_data    = mem[rbin_r[AW-1:0]];

   // Storage, no reset needed
   always_ff @(posedge wclk) begin
      if (do_push) mem[wbin_r[AW-1:0]] <= w_data;
   end

   // Write pointer
   always_ff @(posedge wclk) begin
      if (!wrst_n) begin
         wbin_r  <= '0;
         wgray_r <= '0;
      end else if (do_push) begin
         wbin_r  <= wbin_nxt;
         wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
      end
   end

   // Read pointer
   always_ff @(posedge rclk) begin
      if (!rrst_n) begin
         rbin_r  <= '0;
         rgray_r <= '0;
      end else if (do_pop) begin
         rbin_r  <= rbin_nxt;
         rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
      end
   end
endmodule // mmccb_async_fifo
`default_nettype wire

// ### verif/mmccb_bridge_properties.sv
// Port-level assertions for the clock crossing bridge
`timescale 1ns/1ps
`default_nettype none
module mmccb_bridge_properties #(
   parameter int ADDR_W    = 32,
   parameter int MAX_BURST = 16,
   parameter int RSP_DEPTH = 32
) (
   // Upstream domain
   input wire logic                        aclk,
   input wire logic                        aresetn,
   input wire logic                        ce,
   // Register bus
   input wire logic                        s_axi_awready,
   input wire logic [1:0]                  s_axi_bresp,
   input wire logic                        s_axi_bvalid,
   input wire logic                        s_axi_bready,
   input wire logic                        s_axi_arready,
   input wire logic [31:0]                 s_axi_rdata,
   input wire logic                        s_axi_rvalid,
   input wire logic                        s_axi_rready,
   // Upstream command port
   input wire logic                        s_read,
   input wire logic [$clog2(MAX_BURST):0]  s_burstcount,
   input wire logic                        s_waitrequest,
   input wire logic                        s_readdatavalid,
   // Downstream domain
   input wire logic                        m_clk,
   input wire logic                        m_resetn,
   input wire logic [ADDR_W-1:0]           m_address,
   input wire logic                        m_read,
   input wire logic                        m_write,
   input wire logic [$clog2(MAX_BURST):0]  m_burstcount,
   input wire logic                        m_waitrequest
);
   int ost_r;
   ////////////////////////////////////////////////////////////////////////
   // Read beats owed upstream, charged at acceptance
   always_ff @(posedge aclk) begin
      if (!aresetn) ost_r <= 0;
      else ost_r <= ost_r + ((ce && s_read && !s_waitrequest) ? int'(s_burstcount) : 0) - int'(s_readdatavalid);
   end
   ////////////////////////////////////////////////////////////////////////
   // Upstream domain relations
   property p_ost_bound;
      @(posedge aclk) disable iff (!aresetn) ost_r <= RSP_DEPTH;
   endproperty
   a_ost_bound: assert property (p_ost_bound) else $error("too many reads outstanding");
   property p_beat_owed;
      @(posedge aclk) disable iff (!aresetn) s_readdatavalid |-> ost_r > 0;
   endproperty
   a_beat_owed: assert property (p_beat_owed) else $error("read beat nobody asked for");
   property p_bhold;
      @(posedge aclk) disable iff (!aresetn) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped early");
   property p_rhold;
      @(posedge aclk) disable iff (!aresetn) s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read response dropped early");
   property p_aw_block;
      @(posedge aclk) disable iff (!aresetn) s_axi_bvalid |-> !s_axi_awready;
   endproperty
   a_aw_block: assert property (p_aw_block) else $error("write taken with response pending");
   property p_ar_block;
      @(posedge aclk) disable iff (!aresetn) s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken with response pending");
   ////////////////////////////////////////////////////////////////////////
   // Downstream domain relations
   property p_cmd_hold;
      @(posedge m_clk) disable iff (!m_resetn) (m_read || m_write) && m_waitrequest
         |=> $stable(m_read) && $stable(m_write) && $stable(m_address) && $stable(m_burstcount);
   endproperty
   a_cmd_hold: assert property (p_cmd_hold) else $error("command changed while stalled");
   property p_rw_excl;
      @(posedge m_clk) disable iff (!m_resetn) !(m_read && m_write);
   endproperty
   a_rw_excl: assert property (p_rw_excl) else $error("read and write at once");
endmodule // mmccb_bridge_properties
`default_nettype wire

// ### verif/mmccb_down_slave.sv
// Downstream memory slave model for the bridge master port
`timescale 1ns/1ps
`default_nettype none
module mmccb_down_slave #(
   parameter int AW = 8,
   parameter int BW = 3
) (
   // Clock, reset, pacing
   input  wire logic          m_clk,
   input  wire logic          m_resetn,
   input  wire logic          slow,
   // Command
   input  wire logic [AW-1:0] m_address,
   input  wire logic          m_read,
   input  wire logic          m_write,
   input  wire logic [31:0]   m_writedata,
   input  wire logic [3:0]    m_byteenable,
   input  wire logic [BW-1:0] m_burstcount,
   output logic               m_waitrequest,
   // Read return
   output logic      [31:0]   m_readdata,
   output logic               m_readdatavalid
);
   logic [31:0]   mem [256];
   logic [AW-1:0] pend [$];
   wire           take = (m_read || m_write) && !m_waitrequest;
   ////////////////////////////////////////////////////////////////////////
   // Random stalls; idle data toggles so a stale word never matches
   always @(posedge m_clk) begin
      if (!m_resetn) begin
         m_waitrequest <= 1'b1;
         m_readdatavalid <= 1'b0;
         m_readdata <= 32'h0;
         pend.delete();
      end else begin
         for (int b = 0; b < 4; b++) begin
            if (take && m_write && m_byteenable[b]) mem[m_address][8*b +: 8] <= m_writedata[8*b +: 8];
         end
         if (take && m_read) for (int i = 0; i < int'(m_burstcount); i++) pend.push_back(m_address + AW'(i));
         m_waitrequest <= slow && ($urandom_range(1) == 1);
         if (pend.size() != 0 && !(slow && $urandom_range(3) != 0)) begin
            m_readdatavalid <= 1'b1;
            m_readdata <= mem[pend.pop_front()];
         end else begin
            m_readdatavalid <= 1'b0;
            m_readdata <= ~m_readdata;
         end
      end
   end
endmodule // mmccb_down_slave
`default_nettype wire

// ### verif/mmccb_bridge_tb_top.sv
// Self-checking bench for the clock crossing bridge
`timescale 1ns/1ps
`default_nettype none
module mmccb_bridge_tb_top;
   localparam int AW = 8;
   localparam int MB = 4;
   localparam int BW = $clog2(MB) + 1;
   logic aclk = 0, m_clk = 0, rst_n = 0, slow = 0;
   logic [3:0] awa = 0, ara = 0, wst = 0, sbe = 4'hF;
   logic awv = 0, wv = 0, arv = 0;
   logic [31:0] wd = 0, swd = 0, rd, sdata, mwd, mdata;
   logic awr, wr, bv, arr, rv, swq, sdv, mrd, mwr, mwq, mdv;
   logic [1:0] br, rr;
   logic [AW-1:0] sa = 0, ma;
   logic srd = 0, swr = 0;
   logic [3:0] mbe;
   logic [BW-1:0] sbc = 1, mbc;
   logic [31:0] shadow [256];
   logic [31:0] exp_d [$];
   logic [33:0] exp_r [$];
   logic [1:0] exp_b [$];
   int num_errors = 0;
   int n_checks = 0;
   ////////////////////////////////////////////////////////////////////////
   // Unrelated clocks: rising edges never coincide
   initial forever #2 aclk = ~aclk;
   initial forever #3.5 m_clk = ~m_clk;
   // One reset source for both domains
   mmccb_bridge #(.ADDR_W(AW), .MAX_BURST(MB), .CMD_DEPTH(4), .RSP_DEPTH(8)) u_mmccb_bridge (
      .aclk(aclk), .aresetn(rst_n), .ce(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(wst), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .s_address(sa),
      .s_read(srd), .s_write(swr), .s_writedata(swd), .s_byteenable(sbe), .s_burstcount(sbc),
      .s_waitrequest(swq), .s_readdata(sdata), .s_readdatavalid(sdv), .m_clk(m_clk), .m_resetn(rst_n),
      .m_address(ma), .m_read(mrd), .m_write(mwr), .m_writedata(mwd), .m_byteenable(mbe),
      .m_burstcount(mbc), .m_waitrequest(mwq), .m_readdata(mdata), .m_readdatavalid(mdv));
   mmccb_down_slave #(.AW(AW), .BW(BW)) u_mmccb_down_slave (
      .m_clk(m_clk), .m_resetn(rst_n), .slow(slow), .m_address(ma), .m_read(mrd), .m_write(mwr),
      .m_writedata(mwd), .m_byteenable(mbe), .m_burstcount(mbc), .m_waitrequest(mwq),
      .m_readdata(mdata), .m_readdatavalid(mdv));
   ////////////////////////////////////////////////////////////////////////
   task automatic cmp_word(input logic [33:0] got, input logic [33:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_flag(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      if (num_errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Oldest note against each result as it appears
   always @(posedge aclk) begin
      if (bv) cmp_word({32'h0, br}, {32'h0, exp_b.pop_front()});
      if (rv) cmp_word({rr, rd}, exp_r.pop_front());
      if (sdv) cmp_word({2'h0, sdata}, {2'h0, exp_d.pop_front()});
   end
   ////////////////////////////////////////////////////////////////////////
   // Register bus master, address and data offered together
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
      logic aw_ok = 0, w_ok = 0;
      exp_b.push_back(e);
      awa <= a;
      wd <= d;
      wst <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && awr) begin aw_ok = 1; awv <= 1'b0; end
         if (!w_ok && wr) begin w_ok = 1; wv <= 1'b0; end
      end
      do @(posedge aclk); while (bv !== 1'b1);
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [33:0] e);
      exp_r.push_back(e);
      ara <= a;
      arv <= 1'b1;
      do @(posedge aclk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge aclk); while (rv !== 1'b1);
   endtask
   // Upstream command, held until wait-request is seen low
   task automatic cmd(input logic r, input logic [AW-1:0] a, input logic [BW-1:0] n);
      logic [31:0] d = $urandom;
      logic [3:0] be = (r || $isunknown(shadow[a])) ? 4'hF : 4'($urandom_range(15, 1));
      srd <= r;
      swr <= !r;
      sa <= a;
      sbc <= r ? n : BW'(1);
      swd <= d;
      sbe <= be;
      do @(posedge aclk); while (swq !== 1'b0);
      for (int b = 0; b < 4; b++) if (!r && be[b]) shadow[a][8*b +: 8] = d[8*b +: 8];
      if (r) for (int i = 0; i < int'(n); i++) exp_d.push_back(shadow[a + AW'(i)]);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (40000) @(posedge aclk);
      num_errors++;
      report_and_stop();
   end
   initial begin
      void'($urandom(32'h8096ea15));
      repeat (8) @(posedge aclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge aclk);
      rd_reg(mmccb_pkg::CTRL_OFFSET, {mmccb_pkg::RESP_OKAY, 31'h0, mmccb_pkg::CTRL_ENABLE_RST});
      rd_reg(mmccb_pkg::STATUS_OFFSET, {mmccb_pkg::RESP_OKAY, 32'h0});
      rd_reg(4'h8, {mmccb_pkg::RESP_SLVERR, 32'h0});
      wr_reg(4'hC, 32'h0, 4'hF, mmccb_pkg::RESP_SLVERR);
      wr_reg(mmccb_pkg::STATUS_OFFSET, 32'hFFFF_FFFF, 4'hF, mmccb_pkg::RESP_OKAY);
      wr_reg(mmccb_pkg::CTRL_OFFSET, 32'h0, 4'hE, mmccb_pkg::RESP_OKAY);
      rd_reg(mmccb_pkg::CTRL_OFFSET, {mmccb_pkg::RESP_OKAY, 32'h1});
      // Fill memory with stalls downstream
      slow <= 1'b1;
      for (int a = 0; a < 64; a++) cmd(1'b0, AW'(a), BW'(1));
      swr <= 1'b0;
      // Disabled bridge holds a read off, then lets it through
      wr_reg(mmccb_pkg::CTRL_OFFSET, 32'h0, 4'hF, mmccb_pkg::RESP_OKAY);
      repeat (2) @(posedge aclk);
      fork
         cmd(1'b1, AW'(3), BW'(MB));
         begin
            repeat (8) begin
               @(posedge aclk);
               cmp_flag(swq, 1'b1);
            end
            rd_reg(mmccb_pkg::STATUS_OFFSET, {mmccb_pkg::RESP_OKAY, 32'h0001_0000});
            wr_reg(mmccb_pkg::CTRL_OFFSET, 32'h1, 4'hF, mmccb_pkg::RESP_OKAY);
         end
      join
      // Back-to-back bursts, the first 40 against a slow slave, fill the command queue
      for (int k = 0; k < 80; k++) begin
         slow <= (k < 40);
         cmd(k < 40 || $urandom_range(1) == 1, AW'($urandom_range(59)), BW'($urandom_range(MB, 1)));
      end
      srd <= 1'b0;
      swr <= 1'b0;
      while (exp_d.size() != 0) @(posedge aclk);
      repeat (4) @(posedge aclk);
      rd_reg(mmccb_pkg::STATUS_OFFSET, {mmccb_pkg::RESP_OKAY, 32'h0});
      report_and_stop();
   end
endmodule // mmccb_bridge_tb_top
bind mmccb_bridge mmccb_bridge_properties #(.ADDR_W(ADDR_W), .MAX_BURST(MAX_BURST), .RSP_DEPTH(RSP_DEPTH))
   u_mmccb_bridge_properties (.aclk, .aresetn, .ce, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_read, .s_burstcount, .s_waitrequest,
   .s_readdatavalid, .m_clk, .m_resetn, .m_address, .m_read, .m_write, .m_burstcount, .m_waitrequest);
`default_nettype wire
